// ===== qdw_serial_port.sv
// serial write port with input and dac registers and apb status access
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "qdw_defines.svh"
module qdw_serial_port import qdw_pkg::*; #(
    parameter int DATA_W = `QDW_DATA_W
) (
    input wire logic clk_sys,
    input wire logic reset,
    // link pins
    input wire logic serialClk,
    input wire logic frameSelN,
    input wire logic serialData,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // dac side
    output logic [DATA_W-1:0] dacCodeA,
    output logic [DATA_W-1:0] dacCodeB,
    output logic [DATA_W-1:0] dacCodeC,
    output logic [DATA_W-1:0] dacCodeD,
    output logic outputsEnabled
);
    localparam int NCH = `QDW_NUM_CH;
    localparam logic [`QDW_CNT_W-1:0] FULL_COUNT = `QDW_CNT_W'(`QDW_WORD_BITS);

    // ---------------- link domain (serial clock, falling edge) ----------------
    qdw_word_t shiftReg_q;
    qdw_word_t holdWord_q;
    logic [`QDW_CNT_W-1:0] bitCount_q;
    logic doneToggle_q;
    logic inputsOff;

    // inputs shut off once the word is full, until frame select goes high
    assign inputsOff = (bitCount_q == FULL_COUNT); // R03 R08

    // counter cleared asynchronously while frame select is high
    always_ff @(negedge serialClk or posedge frameSelN) begin
        if (frameSelN) begin
            bitCount_q <= '0; // R10 R05
        end else if (!inputsOff) begin
            bitCount_q <= bitCount_q + `QDW_CNT_W'(1); // R04
        end
    end

    always_ff @(negedge serialClk) begin
        if (!frameSelN && !inputsOff) begin
            shiftReg_q <= {shiftReg_q[`QDW_WORD_BITS-2:0], serialData}; // R01 R02 R06
        end
    end

    // sixteenth falling edge of a frame that is still selected
    logic lastEdge;
    assign lastEdge = !frameSelN && (bitCount_q == FULL_COUNT - `QDW_CNT_W'(1)); // R05

    // last bit lands straight in the hold word
    always_ff @(negedge serialClk or posedge reset) begin
        if (reset) begin
            holdWord_q <= '0;
        end else if (lastEdge) begin
            holdWord_q <= {shiftReg_q[`QDW_WORD_BITS-2:0], serialData}; // R09
        end
    end

    // completion event, flipped once per finished word
    always_ff @(negedge serialClk or posedge reset) begin
        if (reset) begin
            doneToggle_q <= 1'b0;
        end else if (lastEdge) begin
            doneToggle_q <= ~doneToggle_q; // R09
        end
    end

    // ---------------- system domain ----------------
    logic [1:0] linkSync;
    logic toggleSync;
    logic selSync;
    logic togglePrev_q;
    logic wordEvt;

    // toggle and frame select each pass two flops
    qdw_sync2 #(.WIDTH(2)) u_sync (
        .clk(clk_sys),
        .async({doneToggle_q, frameSelN}),
        .synced(linkSync)
    );
    assign toggleSync = linkSync[1];
    assign selSync = linkSync[0];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            togglePrev_q <= 1'b0;
        end else begin
            togglePrev_q <= toggleSync;
        end
    end
    assign wordEvt = toggleSync ^ togglePrev_q;

    // hold word is steady once the toggle is seen, so copy it into this domain
    qdw_word_t wordCap_q;
    logic capValid_q;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wordCap_q <= '0;
        end else if (wordEvt) begin
            wordCap_q <= holdWord_q; // R09
        end
    end

    // copied word is used one cycle after the event
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            capValid_q <= 1'b0;
        end else begin
            capValid_q <= wordEvt;
        end
    end

    logic [31:0] ctrl_q;
    logic enable;
    assign enable = ctrl_q[`QDW_CTRL_EN_BIT];

    qdw_chan_e chan;
    logic [DATA_W-1:0] newCode;
    logic loadAllN;
    logic powerBit;
    logic acceptWord;
    // fields of the accepted word
    assign chan = qdw_chan_e'(wordCap_q[`QDW_CHAN_MSB:`QDW_CHAN_LSB]); // R06
    assign newCode = wordCap_q[`QDW_DATA_MSB -: DATA_W];
    assign loadAllN = wordCap_q[`QDW_LOAD_BIT];
    assign powerBit = wordCap_q[`QDW_PWR_BIT];
    // words are dropped while the enable bit is clear
    assign acceptWord = capValid_q && enable;

    logic [DATA_W-1:0] inReg_q [NCH];
    logic [DATA_W-1:0] dacReg_q [NCH];
    logic [NCH-1:0] inNew_q;
    logic powered_q;
    logic [31:0] frameCount_q;

    // input registers, marked as changed until the next load-all
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < NCH; i++) begin
                inReg_q[i] <= '0;
            end
        end else if (acceptWord) begin
            inReg_q[chan] <= newCode; // R09
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            inNew_q <= '0;
        end else if (acceptWord) begin
            if (!loadAllN) begin
                inNew_q <= '0; // R07
            end else begin
                inNew_q[chan] <= 1'b1;
            end
        end
    end

    // dac registers only take inputs changed since the last load-all
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < NCH; i++) begin
                dacReg_q[i] <= '0;
            end
        end else if (acceptWord && !loadAllN) begin
            for (int i = 0; i < NCH; i++) begin
                if (i == int'(chan)) begin
                    dacReg_q[i] <= newCode; // R07
                end else if (inNew_q[i]) begin
                    dacReg_q[i] <= inReg_q[i]; // R07
                end
            end
        end
    end

    // power bit follows every accepted word
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            powered_q <= 1'b1;
        end else if (acceptWord) begin
            powered_q <= powerBit; // R07
        end
    end

    // counts accepted words only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            frameCount_q <= '0;
        end else if (acceptWord) begin
            frameCount_q <= frameCount_q + 32'h0000_0001;
        end
    end

    // dac side outputs are register copies
    assign dacCodeA = dacReg_q[0];
    assign dacCodeB = dacReg_q[1];
    assign dacCodeC = dacReg_q[2];
    assign dacCodeD = dacReg_q[3];
    assign outputsEnabled = powered_q;

    // ---------------- apb slave, one wait state ----------------
    // ctrl: bit 0 lets finished words through
    // status: power state, synced frame select, changed flags
    // dac a..d: codes the channels show now
    // input a..d: codes waiting for a load-all
    // frame count: words taken since reset
    // unmapped offsets answer with an error and read as zero
    logic access;
    logic doWrite;
    logic [31:0] readVal;
    logic readHit;
    assign access = psel && penable;
    assign doWrite = access && pready && pwrite;

    always_comb begin
        readVal = 32'h0000_0000;
        readHit = 1'b1;
        unique case (paddr)
            `QDW_OFF_CTRL: begin
                readVal = ctrl_q;
            end
            `QDW_OFF_STATUS: begin
                readVal[`QDW_ST_PWR_BIT] = powered_q;
                readVal[`QDW_ST_SEL_BIT] = selSync;
                readVal[`QDW_ST_NEW_LSB +: NCH] = inNew_q;
            end
            `QDW_OFF_DAC_A: begin
                readVal[DATA_W-1:0] = dacReg_q[0];
            end
            `QDW_OFF_DAC_B: begin
                readVal[DATA_W-1:0] = dacReg_q[1];
            end
            `QDW_OFF_DAC_C: begin
                readVal[DATA_W-1:0] = dacReg_q[2];
            end
            `QDW_OFF_DAC_D: begin
                readVal[DATA_W-1:0] = dacReg_q[3];
            end
            `QDW_OFF_IN_A: begin
                readVal[DATA_W-1:0] = inReg_q[0];
            end
            `QDW_OFF_IN_B: begin
                readVal[DATA_W-1:0] = inReg_q[1];
            end
            `QDW_OFF_IN_C: begin
                readVal[DATA_W-1:0] = inReg_q[2];
            end
            `QDW_OFF_IN_D: begin
                readVal[DATA_W-1:0] = inReg_q[3];
            end
            `QDW_OFF_FRAMES: begin
                readVal = frameCount_q;
            end
            default: begin
                readHit = 1'b0;
            end
        endcase
    end

    // answer one cycle after the first access cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= access && !pready;
        end
    end

    // error only with the answer, on unmapped offsets
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= access && !pready && !readHit;
        end
    end

    // read data only with the answer, zero otherwise
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= (access && !pready && !pwrite) ? readVal : 32'h0000_0000;
        end
    end

    // only the enable bit is writable
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_q <= `QDW_CTRL_RESET;
        end else if (doWrite && paddr == `QDW_OFF_CTRL) begin
            ctrl_q <= {31'h0000_0000, pwdata[`QDW_CTRL_EN_BIT]};
        end
    end
endmodule

// ===== qdw_defines.svh
// offsets, field positions, reset values and sizes of the quad dac serial write port
//
// Function
// R01 - The device keeps a shift register exactly sixteen bits wide that receives each frame.
// R02 - Serial data is sampled on the falling serial clock edge, so the host sets each bit up before it.
// R03 - After a completed frame the clock and data inputs are shut off so later pin activity is not captured.
// R04 - Frame select going low enables the shift register, which then takes the next 16 falling edges.
// R05 - Frame select rising before the 16th falling edge aborts the frame and leaves every register unchanged.
// R06 - The word goes most significant bit first and its top two bits pick channel A, B, C or D.
// R07 - Bit 13 low powers down all channels to high impedance; bit 12 low updates every DAC register at the end. The code only clears outputsEnabled.
// R08 - Edges after the sixteenth are ignored and no new frame starts until frame select goes high then low.
// R09 - A completed frame moves the shift register into the input register of the addressed channel.
// R10 - The received-bit counter is cleared whenever frame select is high so each frame counts from zero.
`ifndef QDW_DEFINES_SVH
`define QDW_DEFINES_SVH

`define QDW_WORD_BITS 16
`define QDW_CNT_W 5
`define QDW_CHAN_MSB 15
`define QDW_CHAN_LSB 14
`define QDW_PWR_BIT 13
`define QDW_LOAD_BIT 12
`define QDW_DATA_MSB 11
`define QDW_DATA_W 12
`define QDW_NUM_CH 4

`define QDW_OFF_CTRL 12'h000
`define QDW_OFF_STATUS 12'h004
`define QDW_OFF_DAC_A 12'h008
`define QDW_OFF_DAC_B 12'h00C
`define QDW_OFF_DAC_C 12'h010
`define QDW_OFF_DAC_D 12'h014
`define QDW_OFF_IN_A 12'h018
`define QDW_OFF_IN_B 12'h01C
`define QDW_OFF_IN_C 12'h020
`define QDW_OFF_IN_D 12'h024
`define QDW_OFF_FRAMES 12'h028

`define QDW_CTRL_EN_BIT 0
`define QDW_CTRL_RESET 32'h0000_0001
`define QDW_ST_PWR_BIT 0
`define QDW_ST_SEL_BIT 1
`define QDW_ST_NEW_LSB 4

`endif

// ===== qdw_pkg.sv
// types shared by the quad dac serial write port
package qdw_pkg;
    typedef enum logic [1:0] {
        QDW_CH_A = 2'h0,
        QDW_CH_B = 2'h1,
        QDW_CH_C = 2'h2,
        QDW_CH_D = 2'h3
    } qdw_chan_e;
    typedef logic [15:0] qdw_word_t;
endpackage

// ===== qdw_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module qdw_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge clk) begin
        meta_q <= async;
        synced <= meta_q;
    end
endmodule

// ===== qdw_serial_port_props.sv
// assertions on the serial write port pins
`timescale 1ns/1ps
module qdw_serial_port_props (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic serialClk,
    input wire logic frameSelN,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] dacCodeA,
    input wire logic outputsEnabled
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [4:0] edgeCnt;
    always_ff @(negedge serialClk or posedge frameSelN) begin
        if (frameSelN) edgeCnt <= 5'h00;
        else if (edgeCnt < 5'h10) edgeCnt <= edgeCnt + 5'h01;
    end
    sequence s_setup; psel && !penable; endsequence
    sequence s_wait; psel && penable && !pready; endsequence
    property p_oneWait; s_setup ##1 s_wait |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_errReady; pslverr |-> pready; endproperty
    property p_idleData; !pready |-> prdata == 32'h0; endproperty
    property p_errData; pslverr |-> prdata == 32'h0; endproperty
    property p_codeHold; edgeCnt inside {[4:15]} |-> $stable(dacCodeA); endproperty
    property p_powerHold; edgeCnt inside {[4:15]} |-> $stable(outputsEnabled); endproperty
    property p_abort; edgeCnt inside {[1:12]} ##1 frameSelN |=> $stable(dacCodeA)[*4]; endproperty
    a_oneWait: assert property (p_oneWait) else $error("pready late");
    a_pulse: assert property (p_pulse) else $error("pready long");
    a_errReady: assert property (p_errReady) else $error("lone pslverr");
    a_idleData: assert property (p_idleData) else $error("prdata idle");
    a_errData: assert property (p_errData) else $error("prdata on error");
    a_codeHold: assert property (p_codeHold) else $error("code moved in frame");
    a_powerHold: assert property (p_powerHold) else $error("power moved in frame");
    a_abort: assert property (p_abort) else $error("aborted frame landed");
endmodule

// ===== qdw_host_model.sv
// serial host driving frames at the write port
`timescale 1ns/1ps
module qdw_host_model import qdw_pkg::*; (
    input wire logic go,
    input wire qdw_word_t word,
    input wire logic [4:0] bitCount,
    output logic serialClk,
    output logic frameSelN,
    output logic serialData,
    output logic busy
);
    qdw_word_t sh;
    initial begin
        serialClk = 1'b1;
        frameSelN = 1'b1;
        serialData = 1'b0;
        busy = 1'b0;
    end
    always @(posedge go) begin
        busy = 1'b1;
        sh = word;
        #7 frameSelN = 1'b0;
        for (int i = 0; i < bitCount; i++) begin
            serialData = sh[15];
            sh = {sh[14:0], ~sh[15]};
            #16 serialClk = 1'b0;
            #16 serialClk = 1'b1;
        end
        serialData = ~serialData;
        #20 frameSelN = 1'b1;
        #400 busy = 1'b0;
    end
endmodule

// ===== qdw_serial_port_tb.sv
// self-checking bench for the serial write port
`timescale 1ns/1ps
module qdw_serial_port_tb import qdw_pkg::*;;
    logic clk_sys = 1'b0, reset = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic expEn = 1'b1;
    logic [31:0] expFrames = 32'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, outputsEnabled, serialClk, frameSelN, serialData, busy, er, expOn;
    logic [11:0] dac [4];
    logic [11:0] expIn [4] = '{default: 12'h000};
    logic [11:0] expDac [4] = '{default: 12'h000};
    logic [3:0] chg = 4'h0;
    qdw_word_t word = 16'h0000;
    logic [4:0] bitCount = 5'h10;
    int err_count = 0;
    int compares = 0;
    always #50 clk_sys = ~clk_sys;
    qdw_serial_port i_dut (.clk_sys, .reset, .serialClk, .frameSelN, .serialData, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dacCodeA(dac[0]), .dacCodeB(dac[1]),
        .dacCodeC(dac[2]), .dacCodeD(dac[3]), .outputsEnabled);
    qdw_host_model i_host (.go, .word, .bitCount, .serialClk, .frameSelN, .serialData, .busy);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic void predict(input qdw_word_t w);
        expIn[w[15:14]] = w[11:0];
        chg[w[15:14]] = 1'b1;
        expOn = w[13];
        expFrames = expFrames + 32'h1;
        if (!w[12]) begin
            for (int c = 0; c < 4; c++) if (chg[c]) expDac[c] = expIn[c];
            chg = 4'h0;
        end
    endfunction
    task automatic frame(input qdw_word_t w, input logic [4:0] n);
        @(posedge clk_sys);
        word <= w;
        bitCount <= n;
        go <= 1'b1;
        wait (busy);
        wait (!busy);
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (6) @(posedge clk_sys);
        if (n >= 5'h10 && expEn) predict(w);
        for (int c = 0; c < 4; c++) begin
            apb(1'b0, 12'h018 + 12'(4 * c), 32'h0);
            chk("input", {20'h0, expIn[c]}, rd);
            apb(1'b0, 12'h008 + 12'(4 * c), 32'h0);
            chk("dacreg", {20'h0, expDac[c]}, rd);
            chk("dac", {20'h0, expDac[c]}, {20'h0, dac[c]});
        end
        chk("power", {31'h0, expOn}, {31'h0, outputsEnabled});
        apb(1'b0, 12'h004, 32'h0);
        chk("status", {24'h0, chg, 2'h0, 1'b1, expOn}, rd);
        apb(1'b0, 12'h028, 32'h0);
        chk("frames", expFrames, rd);
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        reset <= 1'b1;
        expOn = 1'b1;
        void'($urandom(90));
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", 32'h0, rd);
        expEn = 1'b0;
        frame(16'h1234, 5'h10);
        expEn = 1'b1;
        apb(1'b1, 12'h000, 32'h1);
        $display("register test done");
        frame(16'h2ABC, 5'h10);
        frame(16'hD123, 5'h14);
        frame(16'h9555, 5'h09);
        frame(16'h0FFF, 5'h0F);
        $display("corner test done");
        for (int k = 0; k < 24; k++) frame(16'($urandom), 5'($urandom_range(20, 8)));
        $display("random test done");
        close_out();
    end
    initial begin
        #3000000;
        err_count++;
        close_out();
    end
endmodule
bind qdw_serial_port qdw_serial_port_props i_props (.clk_sys, .reset, .serialClk, .frameSelN, .psel,
    .penable, .prdata, .pready, .pslverr, .dacCodeA, .outputsEnabled);
